/* llipc_ctrl.sv */
// Low-limit interrupt enables, recalibration times and pin setup behind Wishbone
//
// How it works
// - Bits 9:0 of recal register hold full power recal time, reset 3FF.
// - Bits 15:10 of recal register hold low power recal time, reset 3F.
// - Twelve read/write low-limit enables; bit n governs conversion stage n.
// - Enabled stage with its mask bit set passing below its low threshold drives interrupt output low.
// - Enable at zero removes that stage as a source; enables reset to zero.
// - Pin function 00 off, 01 input, 10 and 11 active-low output.
// - Trigger 00 negative level, 01 rising edge, 10 falling edge, 11 positive level.
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/1ps

module llipc_ctrl
    import llipc_pkg::*;
#(
    parameter int STAGES = NUM_STAGES        // Number of conversion stages
)
(
    input wire logic I_CLOCK,                  // 250 MHz system clock
    input wire logic I_RST_N,                  // Synchronous reset, active low
    input wire logic I_WB_CYC_I,               // Wishbone cycle
    input wire logic I_WB_STB_I,               // Wishbone strobe
    input wire logic I_WB_WE_I,                // Wishbone write enable
    input wire logic [llipc_pkg::WB_AW-1:0] I_WB_ADR_I, // Byte address
    input wire logic [3:0] I_WB_SEL_I,         // Byte lane selects
    input wire logic [llipc_pkg::WB_DW-1:0] I_WB_DAT_I, // Write data
    output logic [llipc_pkg::WB_DW-1:0] O_WB_DAT_O, // Read data
    output logic O_WB_ACK_O,                   // Wishbone acknowledge
    input wire logic [STAGES-1:0] I_STAGE_LOW_EVT, // Result below low threshold
    output logic [llipc_pkg::FP_RECAL_W-1:0] O_FP_RECAL_TIME, // Full power recal
    output logic [llipc_pkg::LP_RECAL_W-1:0] O_LP_RECAL_TIME, // Low power recal
    input wire logic I_GPIO_IN,                // Pin level seen at the pad
    output logic O_GPIO_OUT,                   // Pin drive level
    output logic O_GPIO_OE_N,                  // Pin output enable, low drives
    output logic O_INT_N                       // Interrupt output, active low
);

    // ========================================================================
    // Declarations
    // ========================================================================
    logic [FP_RECAL_W-1:0] full_power_recal_time_reg;
    logic [LP_RECAL_W-1:0] low_power_recal_time_reg;
    logic [STAGES-1:0] stage_low_limit_irq_enable_reg;
    logic [1:0] pin_func_reg;
    logic [1:0] pin_trig_reg;
    logic [IRQ_W-1:0] irq_status_reg;
    logic [IRQ_W-1:0] irq_status_next;
    logic [IRQ_W-1:0] irq_mask_reg;
    logic pin_drive_reg;
    logic gpio_out_reg;
    logic gpio_oe_n_reg;
    logic int_n_reg;
    logic ack_reg;
    logic [WB_DW-1:0] rdata_reg;
    logic [WB_DW-1:0] rdata_next;
    logic [IDX_W-1:0] idx;
    logic req;
    logic wr_go;
    logic rd_go;
    logic status_rd;
    logic [REG_W-1:0] wmask;
    logic [REG_W-1:0] recal_word;
    logic [REG_W-1:0] low_en_word;
    logic [REG_W-1:0] recal_new;
    logic [REG_W-1:0] low_en_new;
    logic [IRQ_W-1:0] irq_events;
    logic [STAGES-1:0] stage_hit;
    logic [IRQ_W-1:0] mask_new;
    logic [IRQ_W-1:0] irq_pending;
    logic pin_event;
    llipc_pin_mode_type pin_mode;

    // ========================================================================
    // Wishbone request decode
    // ========================================================================
    // Address bits above the index and the low byte-offset bits are ignored
    assign idx = I_WB_ADR_I[IDX_W+1:2];
    assign req = I_WB_CYC_I & I_WB_STB_I;
    // Work happens once, on the edge that raises ack
    assign wr_go = req & ~ack_reg & I_WB_WE_I;
    assign rd_go = req & ~ack_reg & ~I_WB_WE_I;
    assign status_rd = rd_go && (idx == IDX_IRQ_STATUS);

    // Byte lanes 0 and 1 carry the 16-bit registers; lanes 2 and 3 are dropped
    genvar b;
    generate
        for (b = 0; b < REG_W; b++) begin : g_wmask
            assign wmask[b] = I_WB_SEL_I[b / 8];
        end
    endgenerate

    // ========================================================================
    // Acknowledge: given one cycle after the request, dropped the cycle after it is given
    // ========================================================================
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req & ~ack_reg;
        end
    end

    // ========================================================================
    // Merged register words
    // ========================================================================
    assign recal_word = {low_power_recal_time_reg, full_power_recal_time_reg};
    assign low_en_word = {pin_trig_reg, pin_func_reg, stage_low_limit_irq_enable_reg};
    assign recal_new = (recal_word & ~wmask) | (I_WB_DAT_I[REG_W-1:0] & wmask);
    assign low_en_new = (low_en_word & ~wmask) | (I_WB_DAT_I[REG_W-1:0] & wmask);
    assign mask_new = (irq_mask_reg & ~wmask[IRQ_W-1:0])
                    | (I_WB_DAT_I[IRQ_W-1:0] & wmask[IRQ_W-1:0]);

    // ========================================================================
    // Recalibration time register
    // ========================================================================
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            full_power_recal_time_reg <= FP_RECAL_RST;
            low_power_recal_time_reg <= LP_RECAL_RST;
        end else if (wr_go && (idx == IDX_RECAL_TIME)) begin
            full_power_recal_time_reg <= recal_new[FP_RECAL_LSB +: FP_RECAL_W];
            low_power_recal_time_reg <= recal_new[LP_RECAL_LSB +: LP_RECAL_W];
        end
    end

    // ========================================================================
    // Low-limit enables and pin setup register
    // ========================================================================
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            stage_low_limit_irq_enable_reg <= LOW_EN_RST;
            pin_func_reg <= PIN_FUNC_RST;
            pin_trig_reg <= PIN_TRIG_RST;
        end else if (wr_go && (idx == IDX_LOW_EN_PIN)) begin
            stage_low_limit_irq_enable_reg <= low_en_new[STAGES-1:0];
            pin_func_reg <= low_en_new[PIN_FUNC_LSB +: 2];
            pin_trig_reg <= low_en_new[PIN_TRIG_LSB +: 2];
        end
    end

    // ========================================================================
    // Interrupt mask and pin drive registers
    // ========================================================================
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            irq_mask_reg <= IRQ_MASK_RST;
        end else if (wr_go && (idx == IDX_IRQ_MASK)) begin
            irq_mask_reg <= mask_new;
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            pin_drive_reg <= 1'b0;
        end else if (wr_go && (idx == IDX_PIN_DRIVE) && I_WB_SEL_I[0]) begin
            pin_drive_reg <= I_WB_DAT_I[0];
        end
    end

    // ========================================================================
    // Pin function decode
    // ========================================================================
    always_comb begin
        case (pin_func_reg)
            FUNC_DISABLED: pin_mode = PIN_OFF;
            FUNC_INPUT: pin_mode = PIN_IN;
            default: pin_mode = PIN_OUT;
        endcase
    end

    // Output is active low: asserting the drive bit pulls the pin low
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            gpio_out_reg <= 1'b1;
            gpio_oe_n_reg <= 1'b1;
        end else begin
            case (pin_mode)
                PIN_OUT: begin
                    gpio_out_reg <= ~pin_drive_reg;
                    gpio_oe_n_reg <= 1'b0;
                end
                PIN_IN: begin
                    gpio_out_reg <= 1'b1;
                    gpio_oe_n_reg <= 1'b1;
                end
                default: begin
                    gpio_out_reg <= 1'b1;
                    gpio_oe_n_reg <= 1'b1;
                end
            endcase
        end
    end

    // ========================================================================
    // Pin trigger detection
    // ========================================================================
    llipc_pin_trigger u_pin_trigger (
        .i_clk(I_CLOCK),
        .i_rst_n(I_RST_N),
        .i_armed(pin_mode == PIN_IN),
        .i_trig(pin_trig_reg),
        .i_pin(I_GPIO_IN),
        .o_event(pin_event)
    );

    // ========================================================================
    // Interrupt sources
    // ========================================================================
    // A disabled stage never reaches the status register at all
    genvar s;
    generate
        for (s = 0; s < STAGES; s++) begin : g_stage
            assign stage_hit[s] = I_STAGE_LOW_EVT[s] & stage_low_limit_irq_enable_reg[s];
        end
    endgenerate

    // Pin trigger sits above the stages so stage n stays at status bit n
    assign irq_events = {pin_event, stage_hit};

    // Read clears the status; a source firing in that same cycle is kept
    always_comb begin
        irq_status_next = irq_status_reg;
        if (status_rd) begin
            irq_status_next = '0;
        end
        irq_status_next = irq_status_next | irq_events;
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            irq_status_reg <= '0;
        end else begin
            irq_status_reg <= irq_status_next;
        end
    end

    // Level sources keep re-setting the status, so the output holds while they last
    assign irq_pending = irq_status_reg & irq_mask_reg;

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            int_n_reg <= 1'b1;
        end else begin
            int_n_reg <= ~(|irq_pending);
        end
    end

    // ========================================================================
    // Read data
    // ========================================================================
    always_comb begin
        rdata_next = '0;
        case (idx)
            IDX_RECAL_TIME: rdata_next[REG_W-1:0] = recal_word;
            IDX_LOW_EN_PIN: rdata_next[REG_W-1:0] = low_en_word;
            IDX_IRQ_STATUS: rdata_next[IRQ_W-1:0] = irq_status_reg;
            IDX_IRQ_MASK: rdata_next[IRQ_W-1:0] = irq_mask_reg;
            IDX_PIN_DRIVE: rdata_next[0] = pin_drive_reg;
            IDX_LIVE_STATE: begin
                rdata_next[STAGES-1:0] = I_STAGE_LOW_EVT;
                rdata_next[LIVE_PIN_BIT] = I_GPIO_IN;
                rdata_next[LIVE_INT_BIT] = ~int_n_reg;
                rdata_next[LIVE_FUNC_LSB +: 2] = pin_func_reg;
            end
            default: rdata_next = '0;
        endcase
    end

    // Unmapped addresses still answer, with zero, so the bus never hangs
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            rdata_reg <= '0;
        end else if (rd_go) begin
            rdata_reg <= rdata_next;
        end
    end

    // ========================================================================
    // Outputs
    // ========================================================================
    assign O_WB_ACK_O = ack_reg;
    assign O_WB_DAT_O = rdata_reg;
    assign O_FP_RECAL_TIME = full_power_recal_time_reg;
    assign O_LP_RECAL_TIME = low_power_recal_time_reg;
    assign O_GPIO_OUT = gpio_out_reg;
    assign O_GPIO_OE_N = gpio_oe_n_reg;
    assign O_INT_N = int_n_reg;

endmodule // llipc_ctrl

/* llipc_ctrl_assertions.sv */
// Port-level checks for the low-limit interrupt and pin configuration block
`timescale 1ns/1ps
module llipc_ctrl_assertions
    import llipc_pkg::*;
(
    input wire logic I_CLOCK, // Clock
    input wire logic I_RST_N, // Reset, active low
    input wire logic I_WB_CYC_I, // Cycle
    input wire logic I_WB_STB_I, // Strobe
    input wire logic I_WB_WE_I, // Write enable
    input wire logic [llipc_pkg::WB_AW-1:0] I_WB_ADR_I, // Address
    input wire logic [3:0] I_WB_SEL_I, // Lanes
    input wire logic [llipc_pkg::WB_DW-1:0] I_WB_DAT_I, // Write data
    input wire logic [llipc_pkg::WB_DW-1:0] O_WB_DAT_O, // Read data
    input wire logic O_WB_ACK_O, // Acknowledge
    input wire logic [llipc_pkg::FP_RECAL_W-1:0] O_FP_RECAL_TIME, // Full power
    input wire logic [llipc_pkg::LP_RECAL_W-1:0] O_LP_RECAL_TIME, // Low power
    input wire logic O_GPIO_OUT, // Pin level
    input wire logic O_GPIO_OE_N, // Pin enable
    input wire logic O_INT_N // Interrupt
);
    logic wr_take;
    logic rc_any;
    logic rc_take;
    logic pc_take;
    assign wr_take = I_WB_CYC_I & I_WB_STB_I & I_WB_WE_I & !O_WB_ACK_O;
    assign rc_any = wr_take & (I_WB_ADR_I[7:2] == IDX_RECAL_TIME);
    assign rc_take = rc_any & (I_WB_SEL_I[1:0] == 2'b11);
    assign pc_take = wr_take & (I_WB_ADR_I[7:2] == IDX_LOW_EN_PIN) & I_WB_SEL_I[1];
    default clocking cb @(posedge I_CLOCK);
    endclocking
    default disable iff (!I_RST_N);
    // =====================================================================
    // Register fields and pin
    AST_RECAL_RST: assert property ($rose(I_RST_N) |->
        O_FP_RECAL_TIME == FP_RECAL_RST && O_LP_RECAL_TIME == LP_RECAL_RST)
        else $error("recal times wrong after reset");
    AST_FP_WRITE: assert property (rc_take |->
        ##2 O_FP_RECAL_TIME == $past(I_WB_DAT_I[9:0], 2))
        else $error("full power recal not written");
    AST_LP_WRITE: assert property (rc_take |->
        ##2 O_LP_RECAL_TIME == $past(I_WB_DAT_I[15:10], 2))
        else $error("low power recal not written");
    // Only a bus write may move the recal outputs; reset edges are excluded
    AST_RECAL_HOLD: assert property (($past(I_RST_N) && (!$stable(O_FP_RECAL_TIME)
        || !$stable(O_LP_RECAL_TIME))) |-> ($past(rc_any) || $past(rc_any, 2)))
        else $error("recal moved without write");
    AST_PIN_RST: assert property ($rose(I_RST_N) |-> O_GPIO_OE_N && O_GPIO_OUT)
        else $error("pin not disabled after reset");
    AST_INT_RST: assert property ($rose(I_RST_N) |-> O_INT_N)
        else $error("interrupt active after reset");
    AST_OE_DECODE: assert property (pc_take |->
        ##2 O_GPIO_OE_N == !$past(I_WB_DAT_I[13], 2)) else $error("pin function decode");
    AST_OUT_IDLE: assert property (O_GPIO_OE_N |-> O_GPIO_OUT)
        else $error("pin level low while not driving");
    // =====================================================================
    // Bus handshake
    AST_ACK_NEXT: assert property ((I_WB_CYC_I && I_WB_STB_I && !O_WB_ACK_O) |=> O_WB_ACK_O)
        else $error("ack late");
    AST_ACK_PULSE: assert property (O_WB_ACK_O |=> !O_WB_ACK_O) else $error("ack too long");
    C_RECAL: cover property (rc_take);
    C_INT: cover property ($fell(O_INT_N));
    C_DRIVE: cover property (!O_GPIO_OE_N && !O_GPIO_OUT);
endmodule // llipc_ctrl_assertions

bind llipc_ctrl llipc_ctrl_assertions u_llipc_chk (.I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N),
    .I_WB_CYC_I(I_WB_CYC_I), .I_WB_STB_I(I_WB_STB_I), .I_WB_WE_I(I_WB_WE_I),
    .I_WB_ADR_I(I_WB_ADR_I), .I_WB_SEL_I(I_WB_SEL_I), .I_WB_DAT_I(I_WB_DAT_I),
    .O_WB_DAT_O(O_WB_DAT_O), .O_WB_ACK_O(O_WB_ACK_O), .O_FP_RECAL_TIME(O_FP_RECAL_TIME),
    .O_LP_RECAL_TIME(O_LP_RECAL_TIME), .O_GPIO_OUT(O_GPIO_OUT), .O_GPIO_OE_N(O_GPIO_OE_N),
    .O_INT_N(O_INT_N));

/* llipc_host.sv */
// Host processor model: classic Wishbone master for register access
`timescale 1ns/1ps
module llipc_host
    import llipc_pkg::*;
(
    input wire logic i_clk, // Bus clock
    input wire logic i_ack, // Acknowledge
    input wire logic [llipc_pkg::WB_DW-1:0] i_rdat, // Read data
    output logic o_cyc, // Cycle
    output logic o_stb, // Strobe
    output logic o_we, // Write enable
    output logic [llipc_pkg::WB_AW-1:0] o_adr, // Byte address
    output logic [3:0] o_sel, // Lanes
    output logic [llipc_pkg::WB_DW-1:0] o_dat // Write data
);
    initial begin
        o_cyc = 1'b0;
        o_stb = 1'b0;
        o_we = 1'b0;
        o_adr = 8'h00;
        o_sel = 4'h0;
        o_dat = 32'h0;
    end
    // No cycle limit here: a hang is cut by the bench watchdog
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge i_clk);
        o_cyc <= 1'b1;
        o_stb <= 1'b1;
        o_we <= w;
        o_adr <= a;
        o_sel <= 4'hF;
        o_dat <= d;
        do @(posedge i_clk); while (i_ack !== 1'b1);
        q = i_rdat;
        o_cyc <= 1'b0;
        o_stb <= 1'b0;
        o_we <= 1'b0;
        // Released lines must not keep showing the old request
        o_adr <= ~a;
        o_dat <= ~d;
    endtask
endmodule // llipc_host

/* llipc_pin_trigger.sv */
// Trigger detector for the general-purpose pin when it serves as an input
`timescale 1ns/1ps

module llipc_pin_trigger
    import llipc_pkg::*;
(
    input wire logic i_clk,       // System clock
    input wire logic i_rst_n,     // Synchronous reset, active low
    input wire logic i_armed,     // Pin configured as input
    input wire logic [1:0] i_trig, // Trigger condition select
    input wire logic i_pin,       // Pin level, synchronous to clock
    output logic o_event          // Trigger seen this cycle
);

    logic prev_reg;
    logic hit;

    // ========================================================================
    // Previous pin level for edge detection
    // ========================================================================
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= i_pin;
        end
    end

    // ========================================================================
    // Trigger decode
    // ========================================================================
    always_comb begin
        case (i_trig)
            TRIG_NEG_LEVEL: hit = ~i_pin;
            TRIG_POS_EDGE: hit = i_pin & ~prev_reg;
            TRIG_NEG_EDGE: hit = ~i_pin & prev_reg;
            TRIG_POS_LEVEL: hit = i_pin;
            default: hit = 1'b0;
        endcase
    end

    // Edges are only trusted once armed; the previous level is tracked while disarmed too, so the first armed cycle sees a true edge
    assign o_event = i_armed & hit;

endmodule // llipc_pin_trigger

/* llipc_pkg.sv */
// Constants and types shared by the low-limit interrupt and pin configuration block
package llipc_pkg;

    // ========================================================================
    // Bus geometry
    // ========================================================================
    localparam int WB_DW = 32;
    localparam int WB_AW = 8;
    localparam int IDX_W = 6;
    localparam int REG_W = 16;
    localparam int NUM_STAGES = 12;

    // ========================================================================
    // Register indices (byte address = index * 4)
    // ========================================================================
    localparam logic [IDX_W-1:0] IDX_RECAL_TIME = 6'h04;
    localparam logic [IDX_W-1:0] IDX_LOW_EN_PIN = 6'h05;
    localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 6'h08;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 6'h09;
    localparam logic [IDX_W-1:0] IDX_PIN_DRIVE = 6'h0A;
    localparam logic [IDX_W-1:0] IDX_LIVE_STATE = 6'h0B;

    // ========================================================================
    // Field positions
    // ========================================================================
    localparam int FP_RECAL_LSB = 0;
    localparam int FP_RECAL_W = 10;
    localparam int LP_RECAL_LSB = 10;
    localparam int LP_RECAL_W = 6;
    localparam int PIN_FUNC_LSB = 12;
    localparam int PIN_TRIG_LSB = 14;
    localparam int IRQ_PIN_BIT = 12;
    localparam int IRQ_W = 13;
    localparam int LIVE_PIN_BIT = 12;
    localparam int LIVE_INT_BIT = 13;
    localparam int LIVE_FUNC_LSB = 14;

    // ========================================================================
    // Reset values
    // ========================================================================
    localparam logic [FP_RECAL_W-1:0] FP_RECAL_RST = 10'h3FF;
    localparam logic [LP_RECAL_W-1:0] LP_RECAL_RST = 6'h3F;
    localparam logic [NUM_STAGES-1:0] LOW_EN_RST = 12'h000;
    localparam logic [1:0] PIN_FUNC_RST = 2'h0;
    localparam logic [1:0] PIN_TRIG_RST = 2'h0;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 13'h1FFF;

    // ========================================================================
    // Field encodings
    // ========================================================================
    localparam logic [1:0] FUNC_DISABLED = 2'h0;
    localparam logic [1:0] FUNC_INPUT = 2'h1;
    localparam logic [1:0] TRIG_NEG_LEVEL = 2'h0;
    localparam logic [1:0] TRIG_POS_EDGE = 2'h1;
    localparam logic [1:0] TRIG_NEG_EDGE = 2'h2;
    localparam logic [1:0] TRIG_POS_LEVEL = 2'h3;

    typedef enum logic [2:0] {
        PIN_OFF = 3'b001,
        PIN_IN = 3'b010,
        PIN_OUT = 3'b100
    } llipc_pin_mode_type;

endpackage : llipc_pkg

/* tb_top.sv */
// Self-checking bench for the low-limit interrupt and pin configuration block
`timescale 1ns/1ps
module tb_top;
    import llipc_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cyc, stb, we, ack, gpio_out, oe_n, int_n, gpio_in;
    logic pin_drv = 1'b1;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat;
    logic [11:0] evt = 12'h000;
    logic [9:0] fp;
    logic [5:0] lp;
    int errors = 0;
    int checks_done = 0;
    always #2 clk = ~clk;
    // The pad follows the block while it drives, the outside world otherwise
    assign gpio_in = oe_n ? pin_drv : gpio_out;
    llipc_ctrl #(.STAGES(NUM_STAGES)) DUT (.I_CLOCK(clk), .I_RST_N(rst_n), .I_WB_CYC_I(cyc),
        .I_WB_STB_I(stb), .I_WB_WE_I(we), .I_WB_ADR_I(adr), .I_WB_SEL_I(sel),
        .I_WB_DAT_I(wdat), .O_WB_DAT_O(rdat), .O_WB_ACK_O(ack), .I_STAGE_LOW_EVT(evt),
        .O_FP_RECAL_TIME(fp), .O_LP_RECAL_TIME(lp), .I_GPIO_IN(gpio_in),
        .O_GPIO_OUT(gpio_out), .O_GPIO_OE_N(oe_n), .O_INT_N(int_n));
    llipc_host u_host (.i_clk(clk), .i_ack(ack), .i_rdat(rdat), .o_cyc(cyc), .o_stb(stb),
        .o_we(we), .o_adr(adr), .o_sel(sel), .o_dat(wdat));
    // =====================================================================
    // Helpers
    function automatic logic exp_int(input logic [11:0] e, n, input logic [12:0] m);
        return !(|(e & n & m[11:0]));
    endfunction
    function automatic logic exp_out(input logic [1:0] f, input logic d);
        return f[1] ? !d : 1'b1;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        u_host.xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        u_host.xfer(1'b0, a, 32'h0, q);
        check(q, exp);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        tick(5000);
        errors++;
        close_out();
    end
    // =====================================================================
    // Main sequence
    initial begin
        logic [31:0] v;
        logic [11:0] ev, en;
        logic [12:0] msk;
        logic [1:0] fv;
        logic d;
        void'($urandom(32'h631e41fb));
        tick(8);
        rst_n <= 1'b1;
        tick(1);
        check(int_n, 1'b1);
        check(oe_n, 1'b1);
        rd(8'h10, 32'h0000FFFF);
        rd(8'h14, 32'h00000000);
        rd(8'h24, 32'h00001FFF);
        for (int i = 0; i < 6; i++) begin
            v = (i == 0) ? 32'h0 : (i == 1) ? 32'hFFFFFFFF : $urandom;
            wr(8'h10, v);
            rd(8'h10, {16'h0, v[15:0]});
            check(fp, v[9:0]);
            check(lp, v[15:10]);
        end
        wr(8'h3C, 32'hFFFF);
        rd(8'h3C, 32'h0);
        for (int n = 0; n < 14; n++) begin
            en = (n < 12) ? (12'h001 << n) : (n == 12) ? 12'h000 : 12'($urandom);
            ev = 12'($urandom) | (12'h001 << (n % 12));
            msk = n[0] ? 13'h1FFF : 13'($urandom);
            wr(8'h14, {20'h0, en});
            wr(8'h24, {19'h0, msk});
            rd(8'h14, {20'h0, en});
            rd(8'h24, {19'h0, msk});
            @(posedge clk) evt <= ev;
            @(posedge clk) evt <= 12'h000;
            tick(2);
            check(int_n, exp_int(ev, en, msk));
            rd(8'h20, {20'h0, ev & en});
            tick(1);
            check(int_n, 1'b1);
        end
        wr(8'h24, 32'h1FFF);
        for (int f = 0; f < 4; f++) begin
            fv = 2'(f);
            d = 1'($urandom);
            wr(8'h14, {18'h0, fv, 12'h000});
            wr(8'h28, {31'h0, d});
            rd(8'h28, {31'h0, d});
            tick(1);
            check(oe_n, !fv[1]);
            check(gpio_out, exp_out(fv, d));
        end
        for (int t = 0; t < 4; t++) begin
            fv = 2'(t);
            wr(8'h14, 32'h0);
            @(posedge clk) pin_drv <= !fv[0];
            wr(8'h14, {16'h0, fv, 2'b01, 12'h000});
            rd(8'h20, 32'h0);
            @(posedge clk) pin_drv <= fv[0];
            @(posedge clk) pin_drv <= !fv[0];
            tick(2);
            check(int_n, 1'b0);
            rd(8'h2C, {16'h0, 2'b01, 1'b1, !fv[0], 12'h000});
            rd(8'h20, 32'h00001000);
        end
        close_out();
    end
endmodule // tb_top
